/* File: src/memory_checker.sv */
// Block signature checker: 32-bit programmable LFSR fed 16 bits a step.
// Assumes all inputs come from logic on the same clock.
//
// Notes on behaviour
// RULE1 - The signature is a 32-bit shift register updated by polynomial division per word.
// RULE2 - Each accepted 16-bit word is folded into the signature in one step.
// RULE3 - The feedback polynomial is loaded by configuration, not fixed.
// RULE4 - A loadable word counter sets the block length and the result completes on expiry.
// RULE5 - A failed block check raises an interrupt pulse when the enable is set.
// RULE6 - The finished signature is compared in hardware against an expected value.
// RULE7 - Outside a block the register can be stepped to give pseudo-random values.
// RULE8 - Seed, polynomial and length are loaded before the first word, result read after expiry.
`timescale 1ns/1ps
`include "checker_consts.svh"

module memory_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Block set-up
  input wire logic start,
  input wire logic [`SIG_W-1:0] seed,
  input wire logic [`SIG_W-1:0] poly,
  input wire logic [`CNT_W-1:0] block_len,
  input wire logic [`SIG_W-1:0] expected,
  input wire logic irq_enable,
  // Data stream
  input wire logic data_valid,
  input wire logic [`WORD_W-1:0] data_in,
  // Random number stepping
  input wire logic prng_step,
  // Results
  output logic data_ready,
  output logic [`SIG_W-1:0] signature,
  output logic [`CNT_W-1:0] words_left,
  output logic block_done,
  output logic crc_error,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  checker_pkg::chk_state_t state_r, state_nxt;
  logic [`SIG_W-1:0] sig_r, sig_nxt;
  logic [`SIG_W-1:0] poly_r, poly_nxt;
  logic [`SIG_W-1:0] exp_r, exp_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic err_r, err_nxt;
  logic irq_r, irq_nxt;
  logic ready_r, ready_nxt;
  logic accept;
  logic last;

  lfsr_step_if stp ();

  // ----------------------------------------------------------------
  // Division engine
  // ----------------------------------------------------------------
  // Idle stepping feeds zeros so the register runs as a plain LFSR
  assign stp.cur = sig_r; // RULE1
  assign stp.poly = poly_r; // RULE3
  assign stp.data = (state_r == checker_pkg::ST_RUN) ? data_in : `PRNG_FILL;

  lfsr_step u_step (
    .stp (stp)
  );

  assign accept = ready_r && data_valid;
  assign last = (cnt_r == `CNT_ONE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    sig_nxt = sig_r;
    poly_nxt = poly_r;
    exp_nxt = exp_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    err_nxt = err_r;
    irq_nxt = 1'b0;
    if (start) begin
      // New block: load seed, polynomial, length and reference
      sig_nxt = seed;
      poly_nxt = poly; // RULE3
      exp_nxt = expected;
      cnt_nxt = block_len; // RULE4
      err_nxt = 1'b0;
      // Zero length would never expire, so it finishes at once on the seed
      if (block_len == `CNT_ZERO) begin
        state_nxt = checker_pkg::ST_DONE;
        done_nxt = 1'b1;
        err_nxt = (seed != expected); // RULE6
        irq_nxt = irq_enable && (seed != expected); // RULE5
      end else begin
        state_nxt = checker_pkg::ST_RUN;
      end
    end else begin
      unique case (state_r)
        checker_pkg::ST_RUN: begin
          if (accept) begin
            sig_nxt = stp.nxt; // RULE2
            cnt_nxt = cnt_r - `CNT_ONE; // RULE4
            if (last) begin
              state_nxt = checker_pkg::ST_DONE;
              done_nxt = 1'b1; // RULE4
              err_nxt = (stp.nxt != exp_r); // RULE6
              irq_nxt = irq_enable && (stp.nxt != exp_r); // RULE5
            end
          end
        end
        checker_pkg::ST_IDLE, checker_pkg::ST_DONE: begin
          if (prng_step) begin
            sig_nxt = stp.nxt; // RULE7
          end
        end
        default: begin
          state_nxt = checker_pkg::ST_IDLE;
        end
      endcase
    end
    ready_nxt = (state_nxt == checker_pkg::ST_RUN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= checker_pkg::ST_IDLE;
      sig_r <= `SIG_RESET;
      poly_r <= `POLY_RESET;
      exp_r <= `SIG_RESET;
      cnt_r <= `CNT_ZERO;
      done_r <= 1'b0;
      err_r <= 1'b0;
      irq_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sig_r <= sig_nxt;
      poly_r <= poly_nxt;
      exp_r <= exp_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      irq_r <= irq_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign data_ready = ready_r;
  assign signature = sig_r;
  assign words_left = cnt_r;
  assign block_done = done_r;
  assign crc_error = err_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_word_fold: assert property ( // RULE2
    !start && accept |=> sig_r == $past(stp.nxt) && cnt_r == $past(cnt_r) - `CNT_ONE)
    else $error("accepted word not folded into signature");

  a_sig_hold: assert property ( // RULE1
    !start && !accept && !prng_step |=> $stable(sig_r))
    else $error("signature changed without a word or step");

  a_poly_kept: assert property ( // RULE3
    !start |=> $stable(poly_r))
    else $error("polynomial changed outside a block load");

  a_len_loaded: assert property ( // RULE4
    start && block_len != `CNT_ZERO |=> cnt_r == $past(block_len) && ready_r)
    else $error("block length not loaded at start");

  a_done_expiry: assert property ( // RULE4
    !start && accept && last |=> done_r && !ready_r ##1 (!done_r || $past(start)))
    else $error("block end not flagged on counter expiry");

  a_compare_out: assert property ( // RULE6
    done_r |-> err_r == (sig_r != exp_r))
    else $error("compare result disagrees with signature");

  a_irq_gate: assert property ( // RULE5
    irq_r |-> done_r && err_r && $past(irq_enable))
    else $error("interrupt without failed check or enable");

  a_irq_fail: assert property ( // RULE5
    !start && accept && last && irq_enable && stp.nxt != exp_r |=> irq_r)
    else $error("failed check did not raise interrupt");

  a_prng_step: assert property ( // RULE7
    !start && !ready_r && prng_step |=> sig_r == $past(stp.nxt))
    else $error("idle step did not advance register");

  // A word offered outside a block must leave no trace
  a_idle_refuse: assert property ( // RULE4
    !start && !ready_r && data_valid && !prng_step |=> $stable(sig_r) && $stable(cnt_r))
    else $error("word taken while no block runs");

  // Zero length never counts down, so it must finish on the seed at once
  a_zero_len: assert property ( // RULE4
    start && block_len == `CNT_ZERO |=> done_r && !ready_r && sig_r == $past(seed))
    else $error("empty block did not finish on the seed");

  a_err_hold: assert property ( // RULE6
    !start && !(accept && last) |=> $stable(err_r))
    else $error("compare result changed outside block end");

  a_start_load: assert property ( // RULE3
    start |=> sig_r == $past(seed) && poly_r == $past(poly) && exp_r == $past(expected))
    else $error("block set-up not loaded at start");

  c_block_pass: cover property (start ##[1:40] (done_r && !err_r));
  c_block_fail_irq: cover property (done_r && irq_r);
  c_prng_run: cover property (!ready_r && prng_step ##1 prng_step);
  c_stall_word: cover property (ready_r && !data_valid ##1 accept);
  c_zero_len: cover property (start && block_len == `CNT_ZERO);

endmodule : memory_checker

/* File: shared/checker_consts.svh */
// Constants for the block signature checker.
// Assumes inclusion by bare name from the shared folder.
`ifndef CHECKER_CONSTS_SVH
`define CHECKER_CONSTS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SIG_W 32
`define WORD_W 16
`define CNT_W 16

// ----------------------------------------------------------------
// Reset values and fixed fills
// ----------------------------------------------------------------
`define SIG_RESET 32'h0000_0000
`define POLY_RESET 32'h0000_0000
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define PRNG_FILL 16'h0000

`endif

/* File: shared/checker_pkg.sv */
// Types shared by the block signature checker files.
// Assumes checker_consts.svh is on the include path.
package checker_pkg;

  // Run state of the block engine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE
  } chk_state_t;

endpackage : checker_pkg

/* File: shared/lfsr_step_if.sv */
// Interface carrying one parallel compression step.
// Assumes the engine end is purely combinational.
`timescale 1ns/1ps
`include "checker_consts.svh"

interface lfsr_step_if;
  logic [`SIG_W-1:0] cur;
  logic [`SIG_W-1:0] poly;
  logic [`WORD_W-1:0] data;
  logic [`SIG_W-1:0] nxt;

  // Engine computes, user supplies operands
  modport engine (input cur, input poly, input data, output nxt);
  modport user (output cur, output poly, output data, input nxt);
endinterface : lfsr_step_if

/* File: src/lfsr_step.sv */
// Sixteen-bit parallel division step of the signature register.
// Assumes operands are stable within the cycle; no state kept here.
`timescale 1ns/1ps
`include "checker_consts.svh"

module lfsr_step (
  // Operands and result
  lfsr_step_if.engine stp
);

  // ----------------------------------------------------------------
  // Unrolled bit-serial division, MSB of the word first
  // ----------------------------------------------------------------
  // Loop folds all word bits in one cycle; depth grows with WORD_W
  always_comb begin
    logic [`SIG_W-1:0] acc;
    logic fb;
    acc = stp.cur;
    fb = 1'b0;
    for (int i = `WORD_W - 1; i >= 0; i--) begin
      fb = acc[`SIG_W-1] ^ stp.data[i];
      acc = {acc[`SIG_W-2:0], 1'b0} ^ (fb ? stp.poly : `POLY_RESET);
    end
    stp.nxt = acc;
  end

endmodule : lfsr_step

/* File: testbench/memory_checker_tb.sv */
// Self-checking bench for the block signature checker: empty, random, random-step and mid-run reset runs.
// Assumes checker_consts.svh on the include path; the design carries its own assertions.
`timescale 1ns/1ps
`include "checker_consts.svh"

module memory_checker_tb;
  // ----------------------------------------------------------------
  // Stimulus, results and bookkeeping
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SIG_W-1:0] sig;
    logic err;
    logic irq;
  } note_t;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic start = 1'h0;
  logic [`SIG_W-1:0] seed = 32'h0;
  logic [`SIG_W-1:0] poly = 32'h0;
  logic [`CNT_W-1:0] block_len = 16'h0;
  logic [`SIG_W-1:0] expected = 32'h0;
  logic irq_enable = 1'h0;
  logic data_valid = 1'h0;
  logic [`WORD_W-1:0] data_in = 16'h0;
  logic prng_step = 1'h0;
  logic data_ready;
  logic [`SIG_W-1:0] signature;
  logic [`CNT_W-1:0] words_left;
  logic block_done;
  logic crc_error;
  logic irq;
  note_t exp_q[$];
  note_t seen;
  logic [`SIG_W-1:0] cur_sig;
  logic [`SIG_W-1:0] cur_poly;
  int miscompares = 0;
  int cmp_count = 0;

  memory_checker dut (
    .clock(clock), .resetn(resetn), .start(start), .seed(seed), .poly(poly),
    .block_len(block_len), .expected(expected), .irq_enable(irq_enable),
    .data_valid(data_valid), .data_in(data_in), .prng_step(prng_step),
    .data_ready(data_ready), .signature(signature), .words_left(words_left),
    .block_done(block_done), .crc_error(crc_error), .irq(irq)
  );

  // 20 MHz clock
  initial begin
    forever #25 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  // One word, MSB first, written apart from the design's own step
  function automatic logic [31:0] step(input logic [31:0] s, p, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      s = {s[30:0], 1'h0} ^ ((s[31] ^ d[i]) ? p : 32'h0);
    end
    return s;
  endfunction : step

  task automatic check(input string what, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Note the result, start the block, feed its words with random stalls, then offer one too many
  task automatic run_block(input logic [31:0] p, s, input int len, input logic bad, en);
    logic [15:0] w[4];
    logic [31:0] m;
    m = s;
    for (int i = 0; i < len; i++) begin
      w[i] = 16'($urandom);
      m = step(m, p, w[i]);
    end
    exp_q.push_back('{m, bad, bad & en});
    @(negedge clock);
    // Whole set-up stands on the pins before the first word
    start = 1'h1;
    seed = s;
    poly = p;
    block_len = 16'(len);
    expected = bad ? (m ^ 32'h1) : m;
    irq_enable = en;
    for (int i = 0; i < len; i++) begin
      @(negedge clock);
      start = 1'h0;
      check("words_left", 32'(len - i), 32'(words_left));
      check("data_ready", 32'h1, 32'(data_ready));
      if ($urandom % 4 == 0) begin
        // Stall one cycle so the engine must hold its count
        data_valid = 1'h0;
        @(negedge clock);
      end
      data_valid = 1'h1;
      data_in = w[i];
    end
    @(negedge clock);
    start = 1'h0;
    check("words_left at end", 32'h0, 32'(words_left));
    check("data_ready at end", 32'h0, 32'(data_ready));
    data_valid = 1'h1;
    data_in = ~data_in;
    @(negedge clock);
    data_valid = 1'h0;
    // Result read only after expiry; the extra word must not have moved it
    check("signature after extra word", m, signature);
    check("crc_error held", 32'(bad), 32'(crc_error));
    repeat (2) @(negedge clock);
    cur_sig = m;
    cur_poly = p;
  endtask : run_block

  // ----------------------------------------------------------------
  // Result watcher: one note taken per finished block
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    #1;
    if (block_done === 1'h1) begin
      if (exp_q.size() == 0) begin
        check("unexpected done", 32'h0, 32'h1);
      end else begin
        seen = exp_q.pop_front();
        check("signature", seen.sig, signature);
        check("crc_error", 32'(seen.err), 32'(crc_error));
        check("irq", 32'(seen.irq), 32'(irq));
      end
    end else if (irq === 1'h1) begin
      check("irq outside done", 32'h0, 32'h1);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h101707aa));
    repeat (2) @(negedge clock);
    resetn = 1'h1;
    run_block(32'h1 | $urandom, $urandom, 0, 1'h1, 1'h1);
    $display("test empty block finished");
    for (int t = 0; t < 16; t++) begin
      run_block(32'h1 | $urandom, $urandom, 1 + $urandom % 4, 1'($urandom), 1'($urandom));
    end
    $display("test random blocks finished");
    @(negedge clock);
    prng_step = 1'h1;
    repeat (5) @(negedge clock);
    prng_step = 1'h0;
    for (int i = 0; i < 5; i++) begin
      cur_sig = step(cur_sig, cur_poly, 16'h0);
    end
    check("random value", cur_sig, signature);
    $display("test random stepping finished");
    // Reset in mid-block: everything returns to idle at once
    @(negedge clock);
    start = 1'h1;
    block_len = 16'h3;
    @(negedge clock);
    start = 1'h0;
    data_valid = 1'h1;
    @(negedge clock);
    resetn = 1'h0;
    #1;
    check("reset signature", 32'h0, signature);
    check("reset words_left", 32'h0, 32'(words_left));
    check("reset data_ready", 32'h0, 32'(data_ready));
    @(negedge clock);
    resetn = 1'h1;
    data_valid = 1'h0;
    repeat (2) @(negedge clock);
    check("idle after reset", 32'h0, 32'(data_ready));
    check("signature after reset", 32'h0, signature);
    check("blocks pending", 32'h0, 32'(exp_q.size()));
    $display("test mid-run reset finished");
    close_out();
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    close_out();
  end
endmodule : memory_checker_tb
